// *** logic/orp_pkg.sv ***
package orp_pkg;
   // Register offsets (byte addresses on the configuration port)
   localparam logic [11:0] ORP_OFF_OVERRANGE_THRESHOLD   = 12'h211;
   localparam logic [11:0] ORP_OFF_OVERRANGE_OUTPUT_CONFIG  = 12'h213;
   localparam logic [11:0] ORP_OFF_INIT     = 12'h270;
   localparam logic [11:0] ORP_OFF_PWR_B    = 12'h29A;
   localparam logic [11:0] ORP_OFF_PWR_C    = 12'h29B;
   localparam logic [11:0] ORP_OFF_PWR_D    = 12'h29C;
   // Reset values
   localparam logic [7:0]  ORP_RST_OVERRANGE_THRESHOLD   = 8'hF2;
   localparam logic [7:0]  ORP_RST_OVERRANGE_OUTPUT_CONFIG  = 8'h07;
   localparam logic [7:0]  ORP_RST_PWR_B    = 8'h0F;
   localparam logic [7:0]  ORP_RST_PWR_C    = 8'h04;
   localparam logic [7:0]  ORP_RST_PWR_D    = 8'h1B;
   // Low-power codes
   localparam logic [7:0]  ORP_LP_PWR_B     = 8'h06;
   localparam logic [7:0]  ORP_LP_PWR_C     = 8'h00;
   localparam logic [7:0]  ORP_LP_PWR_D     = 8'h14;
   // Field positions in the over-range configuration and init registers
   localparam int          ORP_CFG_EN_BIT   = 3;
   localparam int          ORP_CFG_EXP_MSB  = 2;
   localparam int          ORP_CFG_USED_MSB = 3;
   localparam int          ORP_INIT_DONE_BIT = 0;
   // Base hold length in sampling cycles, scaled by 2^exponent
   localparam int          ORP_HOLD_BASE    = 4;
   // Cycles of internal initialization after reset
   localparam int          ORP_INIT_CYCLES  = 16;

   // One register access from the configuration port
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } orp_req_t;

   // Power-mode code summary
   typedef struct packed {
      logic [7:0] code_b;
      logic [7:0] code_c;
      logic [7:0] code_d;
   } orp_pwr_t;
endpackage

// *** logic/orp_regs.sv ***
`timescale 1ns/1ns
module orp_regs #(
   parameter int SW = 12,
   parameter int NCH = 4
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // Register access from the configuration port
   input  orp_pkg::orp_req_t    req,
   output logic [7:0]           rdata,
   output logic                 rvalid,
   // Threshold from its own register outside this block
   input  wire logic [7:0]      overrange_threshold,
   // State of neighbouring enables
   input  wire logic            cal_enable,
   input  wire logic            serial_link_enable,
   // Samples per channel
   input  wire logic [NCH*SW-1:0] samples,
   // Over-range indicators
   output logic [NCH-1:0]       overrange_out,
   // Power configuration
   output orp_pkg::orp_pwr_t    power_codes,
   output logic                 low_power_active,
   output logic                 power_change_unsafe
);
   import orp_pkg::*;

   // --------------------------------------------------------------
   // Configuration registers
   // --------------------------------------------------------------
   logic [7:0] overrange_output_config;
   logic [7:0] power_code_b;
   logic [7:0] power_code_c;
   logic [7:0] power_code_d;
   logic       init_done;
   logic [4:0] init_count;
   logic       wr_pwr;

   // A power-code write is flagged on the raw strobe, before the
   // init gate: a host that writes early while the link or the
   // calibration runs has still broken the sequence and must know.
   // The flag never clears by itself; only a reset takes it away.
   assign wr_pwr = req.wr && (req.addr == ORP_OFF_PWR_B ||
                              req.addr == ORP_OFF_PWR_C ||
                              req.addr == ORP_OFF_PWR_D);

   // Writable registers; upper bits kept as written (software keeps 0)
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         overrange_output_config <= ORP_RST_OVERRANGE_OUTPUT_CONFIG;
         power_code_b <= ORP_RST_PWR_B;
         power_code_c <= ORP_RST_PWR_C;
         power_code_d <= ORP_RST_PWR_D;
      end else if (req.wr && init_done) begin
         // Writes before init done are ignored, protecting the sequence
         unique case (req.addr)
            ORP_OFF_OVERRANGE_OUTPUT_CONFIG: overrange_output_config <= req.wdata;
            ORP_OFF_PWR_B: power_code_b <= req.wdata;
            ORP_OFF_PWR_C: power_code_c <= req.wdata;
            ORP_OFF_PWR_D: power_code_d <= req.wdata;
            default: ;
         endcase
      end
   end

   // --------------------------------------------------------------
   // Initialization sequencer
   // --------------------------------------------------------------
   // The count stands in for the internal start-up work. It stops
   // once done is set, so the counter draws no toggling power while
   // the converter runs. Reads are served during the count, so the
   // host can poll the status bit from the first cycle after reset.
   // init done after count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         init_count <= '0;
         init_done  <= 1'b0;
      end else if (!init_done) begin
         init_count <= init_count + 5'd1;
         init_done  <= (init_count == 5'(ORP_INIT_CYCLES - 1));
      end
   end

   // --------------------------------------------------------------
   // Read path
   // --------------------------------------------------------------
   // Read data is registered and held until the next read, so a
   // slow host may pick it up late. Unmapped addresses return zero
   // rather than stale data, which keeps a bad address visible.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd) begin
            unique case (req.addr)
               ORP_OFF_OVERRANGE_OUTPUT_CONFIG: rdata <= overrange_output_config;
               ORP_OFF_INIT:    rdata <= {7'h00, init_done};
               ORP_OFF_PWR_B:   rdata <= power_code_b;
               ORP_OFF_PWR_C:   rdata <= power_code_c;
               ORP_OFF_PWR_D:   rdata <= power_code_d;
               default:         rdata <= 8'h00;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // Power mode outputs
   // --------------------------------------------------------------
   // The codes leave through flip-flops so that the analog side sees
   // one clean change per write. Low power is reported only when all
   // three codes agree; a mixed set counts as high performance, the
   // safer choice for a converter running above the low-power rate.
   // low-power decode: all three must agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_codes         <= {ORP_RST_PWR_B, ORP_RST_PWR_C,
                                 ORP_RST_PWR_D};
         low_power_active    <= 1'b0;
         power_change_unsafe <= 1'b0;
      end else begin
         power_codes <= {power_code_b, power_code_c, power_code_d};
         low_power_active <= power_code_b == ORP_LP_PWR_B &&
                             power_code_c == ORP_LP_PWR_C &&
                             power_code_d == ORP_LP_PWR_D;
         // flag unsafe change, sticky until reset
         if (wr_pwr && (cal_enable || serial_link_enable)) begin
            power_change_unsafe <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // Over-range channels
   // --------------------------------------------------------------
   // All channels share one threshold, one exponent and one enable.
   // The counter is ten bits wide, enough for the longest hold of
   // 512 sampling cycles at the top exponent. A change of exponent
   // takes effect at the next hit; a hold already running keeps its
   // length, so an exponent write never cuts an indication short.
   // Clearing the enable drops the indicators at the next edge while
   // the counters run on, so re-enabling may show a stale tail.
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         orp_stretch #(.SW(SW), .CW(10)) u_ch (
            .clk       (clk),
            .nrst      (nrst),
            .sample    (samples[g*SW +: SW]),
            .threshold (overrange_threshold),
            .exponent  (overrange_output_config[ORP_CFG_EXP_MSB:0]),
            .enable    (overrange_output_config[ORP_CFG_EN_BIT]),
            .flag      (overrange_out[g])
         );
      end
   endgenerate
endmodule

// *** logic/orp_stretch.sv ***
`timescale 1ns/1ns
// One channel of over-range detection with pulse extension
module orp_stretch #(
   parameter int SW = 12,
   parameter int CW = 10
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          nrst,
   // Sample and settings
   input  wire logic [SW-1:0] sample,
   input  wire logic [7:0]    threshold,
   input  wire logic [2:0]    exponent,
   input  wire logic          enable,
   // Indicator
   output logic               flag
);
   import orp_pkg::*;

   logic [SW-1:0] mag;
   logic          hit;
   logic [CW-1:0] hold_len;
   logic [CW-1:0] count;

   // Magnitude of a signed sample; top 8 bits compare to threshold
   assign mag = sample[SW-1] ? SW'(-sample) : sample;
   assign hit = mag[SW-2 -: 8] >= threshold;
   assign hold_len = CW'(ORP_HOLD_BASE) << exponent;

   // Count down the hold; new hits restart it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (hit) begin
         count <= hold_len;
      end else if (count != '0) begin
         count <= count - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag <= 1'b0;
      end else begin
         flag <= enable && (hit || count > CW'(1));
      end
   end
endmodule

// *** verif/orp_host.sv ***
`timescale 1ns/1ns
// Configuration host: one request at a time, enables it owns
module orp_host (
   // Register access
   input wire logic          clk,
   output orp_pkg::orp_req_t req,
   input wire logic [7:0]    rdata,
   // Neighbouring enables
   output logic              cal_enable,
   output logic              serial_link_enable
);
   import orp_pkg::*;
   initial begin
      req = '0;
      cal_enable = 1'b0;
      serial_link_enable = 1'b1;
   end
   // Both strobes are single-cycle, so requests last exactly one edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] v = (a == ORP_OFF_OVERRANGE_OUTPUT_CONFIG) ? {4'h0, d[3:0]} : d;
      @(posedge clk);
      #5;
      req = '{1'b1, 1'b0, a, v};
      @(posedge clk);
      #5;
      req = '0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      #5;
      req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      #5;
      req = '0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic wait_init();
      logic [7:0] d = 8'h00;
      for (int i = 0; i < 40 && !d[0]; i++) rd(ORP_OFF_INIT, d);
   endtask
   // all three codes one after another, both enables low
   task automatic set_mode(input logic lp);
      @(posedge clk);
      #5;
      cal_enable = 1'b0;
      serial_link_enable = 1'b0;
      wr(ORP_OFF_PWR_B, lp ? ORP_LP_PWR_B : ORP_RST_PWR_B);
      wr(ORP_OFF_PWR_C, lp ? ORP_LP_PWR_C : ORP_RST_PWR_C);
      wr(ORP_OFF_PWR_D, lp ? ORP_LP_PWR_D : ORP_RST_PWR_D);
      cal_enable = 1'b1;
      @(posedge clk);
      #5;
      cal_enable = 1'b0;
   endtask
endmodule

// *** verif/orp_regs_checker.sv ***
`timescale 1ns/1ns
// Port-level watch on the over-range and power-code block
module orp_regs_checker #(
   parameter int SW = 12,
   parameter int NCH = 4
) (
   // Clock, reset and port traffic
   input wire logic              clk,
   input wire logic              nrst,
   input orp_pkg::orp_req_t      req,
   input wire logic [7:0]        rdata,
   input wire logic              rvalid,
   input wire logic [7:0]        overrange_threshold,
   input wire logic [NCH*SW-1:0] samples,
   // Outputs under watch
   input wire logic [NCH-1:0]    overrange_out,
   input orp_pkg::orp_pwr_t      power_codes,
   input wire logic              low_power_active
);
   import orp_pkg::*;
   logic [SW-1:0] mag0;
   logic          hit0;
   logic          lp_codes;
   // Channel 0 level; the most negative code is never driven
   assign mag0 = samples[SW-1] ? -samples[SW-1:0] : samples[SW-1:0];
   assign hit0 = mag0[SW-2 -: 8] >= overrange_threshold;
   assign lp_codes = power_codes == {ORP_LP_PWR_B, ORP_LP_PWR_C,
                                     ORP_LP_PWR_D};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   read_answer_a: assert property (req.rd |=> rvalid)
      else $error("read gave no answer");
   status_bits_a: assert property (
      req.rd && req.addr == ORP_OFF_INIT |=> rdata[7:1] == 7'h00)
      else $error("status upper bits set");
   hold_min_a: assert property (
      $rose(overrange_out[0]) |-> overrange_out[0] [*4])
      else $error("indicator pulse too short");
   hit_cause_a: assert property ($rose(overrange_out[0]) |-> $past(hit0))
      else $error("indicator without a hit");
   lp_code_b_a: assert property (
      low_power_active |-> power_codes.code_b == ORP_LP_PWR_B)
      else $error("low power with code b off");
   lp_code_c_a: assert property (
      low_power_active |-> power_codes.code_c == ORP_LP_PWR_C)
      else $error("low power with code c off");
   lp_code_d_a: assert property (
      low_power_active |-> power_codes.code_d == ORP_LP_PWR_D)
      else $error("low power with code d off");
   lp_decode_a: assert property (lp_codes |-> low_power_active)
      else $error("low power not flagged");
endmodule

bind orp_regs orp_regs_checker #(.SW(SW), .NCH(NCH)) u_chk (.clk(clk),
   .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
   .overrange_threshold(overrange_threshold), .samples(samples),
   .overrange_out(overrange_out), .power_codes(power_codes),
   .low_power_active(low_power_active));

// *** verif/testbench.sv ***
`timescale 1ns/1ns
// Self-checking bench for the over-range and power-code block
module testbench;
   import orp_pkg::*;
   logic clk, nrst, rvalid, cal_enable, serial_link_enable, burst;
   logic low_power_active, power_change_unsafe;
   orp_req_t   req;
   orp_pwr_t   power_codes;
   logic [7:0] rdata, expq[$];
   logic [47:0] samples;
   logic [3:0] overrange_out;
   logic [31:0] seed;
   int miscompares, check_count, cycles;
   orp_regs DUT (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
      .rvalid(rvalid), .overrange_threshold(ORP_RST_OVERRANGE_THRESHOLD),
      .cal_enable(cal_enable), .serial_link_enable(serial_link_enable),
      .samples(samples), .overrange_out(overrange_out),
      .power_codes(power_codes), .low_power_active(low_power_active),
      .power_change_unsafe(power_change_unsafe));
   orp_host host (.clk(clk), .req(req), .rdata(rdata),
      .cal_enable(cal_enable), .serial_link_enable(serial_link_enable));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input string n, input logic [7:0] e, s);
      check_count++;
      if (e !== s) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic expect_rd(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      expq.push_back(e);
      host.rd(a, d);
   endtask
   // Hit pattern in, then count cycles with all four indicators high
   task automatic shoot(input logic [3:0] pat, input int n);
      int cnt = 0;
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         #2;
         burst = i < 4 ? pat[i] : 1'b0;
         if (overrange_out === 4'hF) cnt++;
         else if (cnt > 0) break;
      end
      check("pulse length", n[7:0], cnt[7:0]);
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Random quiet levels stay under the threshold; bursts hit both signs
   always begin
      @(posedge clk);
      #5;
      for (int g = 0; g < 4; g++) begin
         seed = xs(seed);
         samples[g*12 +: 12] = burst ? (g[0] ? 12'h808 : 12'h7F8) :
            (seed[10] ? -{2'b00, seed[9:0]} : {2'b00, seed[9:0]});
      end
   end
   // Read answers pair with the oldest note; status polls leave none
   always @(posedge clk) if (rvalid === 1'b1 && expq.size() > 0)
      check("rdata", expq.pop_front(), rdata);
   // Ceiling far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      {nrst, burst, samples} = '0;
      seed = 32'hBEDE;
      repeat (8) @(posedge clk);
      #5;
      nrst = 1'b1;
      host.wr(ORP_OFF_OVERRANGE_OUTPUT_CONFIG, 8'h0A);
      expect_rd(ORP_OFF_INIT, 8'h00);
      host.wait_init();
      host.wr(ORP_OFF_INIT, 8'hFF);
      expect_rd(ORP_OFF_INIT, 8'h01);
      expect_rd(ORP_OFF_PWR_B, ORP_RST_PWR_B);
      expect_rd(ORP_OFF_PWR_C, ORP_RST_PWR_C);
      expect_rd(ORP_OFF_PWR_D, ORP_RST_PWR_D);
      expect_rd(ORP_OFF_OVERRANGE_OUTPUT_CONFIG, ORP_RST_OVERRANGE_OUTPUT_CONFIG);
      expect_rd(12'h300, 8'h00);
      $display("register reset test done");
      for (int m = 1; m >= 0; m--) begin
         host.set_mode(m[0]);
         expect_rd(ORP_OFF_PWR_C, m ? ORP_LP_PWR_C : ORP_RST_PWR_C);
         #2;
         check("low power", {7'h00, m[0]}, {7'h00, low_power_active});
      end
      $display("power mode test done");
      host.wr(ORP_OFF_OVERRANGE_OUTPUT_CONFIG, 8'h00);
      shoot(4'b0001, 0);
      for (int n = 0; n < 3; n += 2) for (int k = 0; k < 2; k++) begin
         host.wr(ORP_OFF_OVERRANGE_OUTPUT_CONFIG, 8'hF8 | n[7:0]);
         expect_rd(ORP_OFF_OVERRANGE_OUTPUT_CONFIG, 8'h08 | n[7:0]);
         shoot(k ? 4'b1001 : 4'b0001, (4 << n) + 3 * k);
      end
      $display("over-range test done");
      check("pending reads", 8'h00, 8'(expq.size()));
      check("unsafe flag", 8'h00, {7'h00, power_change_unsafe});
      report_and_stop();
   end
endmodule
